// ---- include/spcsr_consts.svh ----
// constants of the spindle control/status register block
`ifndef SPCSR_CONSTS_SVH
`define SPCSR_CONSTS_SVH

`define SPCSR_WORD_W 16
`define SPCSR_CLK_MHZ 250
// control word reset value, all documented defaults
`define SPCSR_CTRL_RESET 16'h756C
// control field positions
`define SPCSR_CB_EXT_FDBK 0
`define SPCSR_CB_FREF_BLOCK 1
`define SPCSR_CB_LOCK_LO 2
`define SPCSR_CB_OUT_DIS 5
`define SPCSR_CB_RUN 6
`define SPCSR_CB_SEQ_RESET 7
`define SPCSR_CB_AUTO 8
`define SPCSR_CB_SEQ_STEP 9
`define SPCSR_CB_PHASE_LO 10
`define SPCSR_CB_START_LO 13
`define SPCSR_CB_ILIM_HALF 15
// lock window times in ns, at the 10 MHz reference clock of the table
`define SPCSR_LOCK_NS_0 6400
`define SPCSR_LOCK_NS_1 12800
`define SPCSR_LOCK_NS_2 25600
`define SPCSR_LOCK_NS_3 51200
`define SPCSR_NS_TO_CYC(ns) (((ns) * `SPCSR_CLK_MHZ) / 1000)
// phase delay in hundredths of an electrical degree
`define SPCSR_PD_0 12'd0
`define SPCSR_PD_1 12'd940
`define SPCSR_PD_2 12'd1880
`define SPCSR_PD_3 12'd2068
`define SPCSR_PD_4 12'd2256
`define SPCSR_PD_5 12'd2444
`define SPCSR_PD_6 12'd2632
`define SPCSR_PD_7 12'd2820
// one zero-crossing interval spans 60 degrees, in hundredths
`define SPCSR_ZC_SPAN_X100 6000
// auto start delay in ms, 90 Hz and 60 Hz columns
`define SPCSR_ASD90_MS_0 711
`define SPCSR_ASD90_MS_1 1422
`define SPCSR_ASD90_MS_2 2133
`define SPCSR_ASD90_MS_3 2844
`define SPCSR_ASD60_MS_0 1070
`define SPCSR_ASD60_MS_1 2130
`define SPCSR_ASD60_MS_2 3200
`define SPCSR_ASD60_MS_3 4270
`define SPCSR_CYC_PER_MS ((`SPCSR_CLK_MHZ) * 1000)
`define SPCSR_BRAKE_DLY_CYC 1000
// pin synchroniser lanes
`define SPCSR_NPIN 9
`define SPCSR_P_STROBE 0
`define SPCSR_P_RW 1
`define SPCSR_P_DIS 2
`define SPCSR_P_RUN 3
`define SPCSR_P_OE 4
`define SPCSR_P_ZC 5
`define SPCSR_P_EXTFB 6
`define SPCSR_P_FREF 7
`define SPCSR_P_R60 8

`endif

// ---- include/spcsr_pkg.sv ----
// types of the spindle control/status register block
package spcsr_pkg;
    typedef struct packed {
        logic ilim_half;
        logic [1:0] start_dly;
        logic [2:0] phase_dly;
        logic seq_step;
        logic auto_start;
        logic seq_reset;
        logic run;
        logic out_dis;
        logic unused;
        logic [1:0] lock_thr;
        logic fref_block;
        logic ext_fdbk;
    } spcsr_ctrl_t;

    typedef struct packed {
        logic [10:0] upper;
        logic go;
        logic delay;
        logic mask;
        logic wrap1;
        logic wrap0;
    } spcsr_status_t;

    typedef enum logic [1:0] {
        SPCSR_ST_IDLE = 2'b00,
        SPCSR_ST_ALIGN = 2'b01,
        SPCSR_ST_RUN = 2'b11,
        SPCSR_ST_BRAKE = 2'b10
    } spcsr_state_t;
endpackage : spcsr_pkg

// ---- design/spcsr_link.sv ----
// serial shift logic running on the host port clock
`timescale 1ns/10ps
`include "spcsr_consts.svh"
module spcsr_link (
    input wire logic port_clk_in,
    input wire logic rst_in,
    input wire logic strobe_in,
    input wire logic write_sel_in,
    input wire logic din_in,
    input wire logic [15:0] status_snap_in,
    output logic [15:0] shift_word_out,
    output logic dout_out
);
    logic [15:0] shift_q;
    logic [3:0] idx_q;
    logic idx_clr;

    // write shift on falling edges, first bit ends in bit 0
    always_ff @(negedge port_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_q <= 16'h0000;
        end else if (write_sel_in) begin
            shift_q <= {din_in, shift_q[15:1]};
        end
    end

    // strobe restarts the read index; clock is idle while it is high
    assign idx_clr = rst_in | strobe_in;

    always_ff @(negedge port_clk_in or posedge idx_clr) begin
        if (idx_clr) begin
            idx_q <= 4'h0;
        end else if (!write_sel_in) begin
            idx_q <= idx_q + 4'h1;
        end
    end

    assign shift_word_out = shift_q;
    // snapshot is frozen while the host clocks, so no crossing hazard
    assign dout_out = status_snap_in[idx_q];
endmodule : spcsr_link

// ---- design/spcsr_regs.sv ----
// control latch, status assembly and serial port of the spindle block
`timescale 1ns/10ps
`include "spcsr_consts.svh"
module spcsr_regs #(
    parameter int unsigned CYC_PER_MS = `SPCSR_CYC_PER_MS,
    parameter int unsigned BRAKE_DLY_CYC = `SPCSR_BRAKE_DLY_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic port_clk_in,
    input wire logic strobe_in,
    input wire logic rw_in,
    input wire logic port_dis_in,
    input wire logic dio_in,
    output logic dio_out,
    output logic dio_oe_out,
    input wire logic run_pin_in,
    input wire logic out_en_pin_in,
    input wire logic zero_cross_in,
    input wire logic ext_fdbk_in,
    input wire logic int_fdbk_in,
    input wire logic fref_in,
    input wire logic ref_60hz_in,
    output logic speed_fdbk_out,
    output logic fref_pd_out,
    output logic [15:0] lock_win_cyc_out,
    output logic drivers_en_out,
    output logic resync_rst_out,
    output logic run_out,
    output logic brake_out,
    output logic auto_start_out,
    output logic [2:0] seq_phase_out,
    output logic commutate_out,
    output logic ilim_half_out,
    output logic [15:0] ctrl_word_out,
    output logic [15:0] status_word_out
);
    spcsr_pkg::spcsr_ctrl_t ctrl_q;
    spcsr_pkg::spcsr_status_t status;
    spcsr_pkg::spcsr_state_t st_q;
    logic [`SPCSR_NPIN-1:0] pin_raw;
    logic [`SPCSR_NPIN-1:0] sync1_q;
    logic [`SPCSR_NPIN-1:0] sync2_q;
    logic strobe_prev_q;
    logic zc_prev_q;
    logic step_prev_q;
    logic run_prev_q;
    logic [15:0] shift_word;
    logic [15:0] snap_q;
    logic write_sel;
    logic run_eff;
    logic zc_rise;
    logic [23:0] iv_cnt_q;
    logic [23:0] iv_q;
    logic [11:0] pd_x100;
    logic [35:0] pd_prod;
    logic [23:0] pd_cyc;
    logic delay_q;
    logic [23:0] dcnt_q;
    logic commutate_q;
    logic mask_q;
    logic mask_wait_q;
    logic [23:0] mcnt_q;
    logic [2:0] phase_q;
    logic [31:0] tcnt_q;
    logic [31:0] asd_cyc;
    logic [15:0] asd_ms;
    logic brake_q;

    // pins from outside the clock domain, two flops each
    assign pin_raw = {ref_60hz_in, fref_in, ext_fdbk_in, zero_cross_in,
                      out_en_pin_in, run_pin_in, port_dis_in, rw_in, strobe_in};

    genvar gi;
    generate
        for (gi = 0; gi < `SPCSR_NPIN; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // edge history of synchronised levels
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            strobe_prev_q <= 1'b0;
            zc_prev_q <= 1'b0;
            step_prev_q <= 1'b0;
            run_prev_q <= 1'b0;
        end else begin
            strobe_prev_q <= sync2_q[`SPCSR_P_STROBE];
            zc_prev_q <= sync2_q[`SPCSR_P_ZC];
            step_prev_q <= ctrl_q.seq_step;
            run_prev_q <= run_eff;
        end
    end

    // data direction follows disable and read/write
    assign write_sel = !sync2_q[`SPCSR_P_DIS] && !sync2_q[`SPCSR_P_RW];
    assign dio_oe_out = !sync2_q[`SPCSR_P_DIS] &&
                        sync2_q[`SPCSR_P_RW];

    spcsr_link u_link (
        .port_clk_in(port_clk_in),
        .rst_in(rst_in),
        .strobe_in(strobe_in),
        .write_sel_in(write_sel),
        .din_in(dio_in),
        .status_snap_in(snap_q),
        .shift_word_out(shift_word),
        .dout_out(dio_out)
    );

    // control latch; shift word is static once the host stops clocking
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= `SPCSR_CTRL_RESET;
        end else if (sync2_q[`SPCSR_P_STROBE] && !strobe_prev_q &&
                     write_sel) begin
            ctrl_q <= shift_word;
        end
    end

    // status flows into the snapshot while strobe is high in read mode
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            snap_q <= 16'h0000;
        end else if (sync2_q[`SPCSR_P_STROBE] && !write_sel) begin
            snap_q <= status;
        end
    end

    // direct decodes of the control word
    assign speed_fdbk_out = ctrl_q.ext_fdbk ? sync2_q[`SPCSR_P_EXTFB]
                                            : int_fdbk_in;
    assign fref_pd_out = sync2_q[`SPCSR_P_FREF] &&
                         !ctrl_q.fref_block;
    assign drivers_en_out = !ctrl_q.out_dis &&
                            sync2_q[`SPCSR_P_OE];
    assign resync_rst_out = ctrl_q.out_dis;
    assign run_eff = ctrl_q.run && sync2_q[`SPCSR_P_RUN];
    assign run_out = run_eff;
    assign auto_start_out = ctrl_q.auto_start;
    assign ilim_half_out = ctrl_q.ilim_half;
    assign ctrl_word_out = ctrl_q;

    // lock window scaled to this clock
    always_comb begin
        case (ctrl_q.lock_thr)
            2'b00: lock_win_cyc_out = 16'(`SPCSR_NS_TO_CYC(`SPCSR_LOCK_NS_0));
            2'b01: lock_win_cyc_out = 16'(`SPCSR_NS_TO_CYC(`SPCSR_LOCK_NS_1));
            2'b10: lock_win_cyc_out = 16'(`SPCSR_NS_TO_CYC(`SPCSR_LOCK_NS_2));
            default: lock_win_cyc_out =
                16'(`SPCSR_NS_TO_CYC(`SPCSR_LOCK_NS_3));
        endcase
    end

    // phase delay in hundredths of a degree
    always_comb begin
        case (ctrl_q.phase_dly)
            3'h0: pd_x100 = `SPCSR_PD_0;
            3'h1: pd_x100 = `SPCSR_PD_1;
            3'h2: pd_x100 = `SPCSR_PD_2;
            3'h3: pd_x100 = `SPCSR_PD_3;
            3'h4: pd_x100 = `SPCSR_PD_4;
            3'h5: pd_x100 = `SPCSR_PD_5;
            3'h6: pd_x100 = `SPCSR_PD_6;
            default: pd_x100 = `SPCSR_PD_7;
        endcase
    end

    // degrees turn into cycles from the last crossing interval
    assign pd_prod = iv_q * pd_x100;
    assign pd_cyc = 24'(pd_prod / 36'(`SPCSR_ZC_SPAN_X100));

    assign zc_rise = sync2_q[`SPCSR_P_ZC] && !zc_prev_q;

    // interval between crossings, saturating for a stalled rotor
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            iv_cnt_q <= 24'h000000;
            iv_q <= 24'h000000;
        end else if (zc_rise) begin
            iv_q <= iv_cnt_q;
            iv_cnt_q <= 24'h000001;
        end else if (iv_cnt_q != 24'hFFFFFF) begin
            iv_cnt_q <= iv_cnt_q + 24'h000001;
        end
    end

    // delay flag; its fall issues the commutation pulse
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            delay_q <= 1'b0;
            dcnt_q <= 24'h000000;
            commutate_q <= 1'b0;
        end else begin
            commutate_q <= 1'b0;
            if (zc_rise) begin
                delay_q <= 1'b1;
                dcnt_q <= pd_cyc;
            end else if (delay_q && dcnt_q == 24'h000000) begin
                delay_q <= 1'b0;
                commutate_q <= 1'b1;
            end else if (delay_q) begin
                dcnt_q <= dcnt_q - 24'h000001;
            end
        end
    end
    assign commutate_out = commutate_q;

    // mask low from crossing until a quarter interval past commutation
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mask_q <= 1'b1;
            mask_wait_q <= 1'b0;
            mcnt_q <= 24'h000000;
        end else if (zc_rise) begin
            mask_q <= 1'b0;
            mask_wait_q <= 1'b0;
        end else if (commutate_q) begin
            mask_wait_q <= 1'b1;
            mcnt_q <= {2'b00, iv_q[23:2]};
        end else if (mask_wait_q && mcnt_q == 24'h000000) begin
            mask_wait_q <= 1'b0;
            mask_q <= 1'b1;
        end else if (mask_wait_q) begin
            mcnt_q <= mcnt_q - 24'h000001;
        end
    end

    // commutation sequencer, phase 1 encoded as zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= 3'h0;
        end else if (ctrl_q.seq_reset ||
                     st_q == spcsr_pkg::SPCSR_ST_BRAKE) begin
            phase_q <= 3'h0;
        end else if (commutate_q || (ctrl_q.seq_step && !step_prev_q)) begin
            phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
        end
    end
    assign seq_phase_out = phase_q;

    // automatic start-up wait, ms figure times cycles per ms
    always_comb begin
        case ({sync2_q[`SPCSR_P_R60], ctrl_q.start_dly})
            3'b000: asd_ms = 16'(`SPCSR_ASD90_MS_0);
            3'b001: asd_ms = 16'(`SPCSR_ASD90_MS_1);
            3'b010: asd_ms = 16'(`SPCSR_ASD90_MS_2);
            3'b011: asd_ms = 16'(`SPCSR_ASD90_MS_3);
            3'b100: asd_ms = 16'(`SPCSR_ASD60_MS_0);
            3'b101: asd_ms = 16'(`SPCSR_ASD60_MS_1);
            3'b110: asd_ms = 16'(`SPCSR_ASD60_MS_2);
            default: asd_ms = 16'(`SPCSR_ASD60_MS_3);
        endcase
    end
    assign asd_cyc = 32'(64'(asd_ms) * 64'(CYC_PER_MS));

    // start-up and brake sequencing; output disable restarts it
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= spcsr_pkg::SPCSR_ST_IDLE;
            tcnt_q <= 32'h00000000;
            brake_q <= 1'b0;
        end else if (ctrl_q.out_dis) begin
            st_q <= spcsr_pkg::SPCSR_ST_IDLE;
            brake_q <= 1'b0;
        end else begin
            case (st_q)
                spcsr_pkg::SPCSR_ST_IDLE: begin
                    if (run_eff && !run_prev_q) begin
                        brake_q <= 1'b0;
                        tcnt_q <= 32'h00000000;
                        st_q <= ctrl_q.auto_start ?
                            spcsr_pkg::SPCSR_ST_ALIGN :
                            spcsr_pkg::SPCSR_ST_RUN;
                    end else if (!run_eff) begin
                        tcnt_q <= 32'h00000000;
                        st_q <= spcsr_pkg::SPCSR_ST_BRAKE;
                    end
                end
                spcsr_pkg::SPCSR_ST_ALIGN: begin
                    if (!run_eff) begin
                        tcnt_q <= 32'h00000000;
                        st_q <= spcsr_pkg::SPCSR_ST_BRAKE;
                    end else if (tcnt_q + 32'h00000001 >= asd_cyc) begin
                        st_q <= spcsr_pkg::SPCSR_ST_RUN;
                    end else begin
                        tcnt_q <= tcnt_q + 32'h00000001;
                    end
                end
                spcsr_pkg::SPCSR_ST_RUN: begin
                    if (!run_eff) begin
                        tcnt_q <= 32'h00000000;
                        st_q <= spcsr_pkg::SPCSR_ST_BRAKE;
                    end
                end
                spcsr_pkg::SPCSR_ST_BRAKE: begin
                    if (run_eff) begin
                        brake_q <= 1'b0;
                        st_q <= spcsr_pkg::SPCSR_ST_IDLE;
                    end else if (tcnt_q + 32'h00000001 >= BRAKE_DLY_CYC) begin
                        brake_q <= 1'b1;
                    end else begin
                        tcnt_q <= tcnt_q + 32'h00000001;
                    end
                end
                default: st_q <= spcsr_pkg::SPCSR_ST_IDLE;
            endcase
        end
    end
    assign brake_out = brake_q;

    // status word; upper bits are outside this block and read zero
    always_comb begin
        status = '0;
        status.wrap0 = ctrl_q.ext_fdbk;
        status.wrap1 = ctrl_q.fref_block;
        status.mask = mask_q && !ctrl_q.seq_step;
        status.delay = delay_q;
        status.go = (st_q != spcsr_pkg::SPCSR_ST_ALIGN);
    end
    assign status_word_out = status;
endmodule : spcsr_regs

// ---- testbench/spcsr_regs_props.sv ----
// assertion checker for the spindle control/status register block
`timescale 1ns/10ps
module spcsr_props (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic strobe_in,
    input wire logic port_dis_in,
    input wire logic int_fdbk_in,
    input wire logic dio_oe_out,
    input wire logic speed_fdbk_out,
    input wire logic fref_pd_out,
    input wire logic resync_rst_out,
    input wire logic [15:0] lock_win_cyc_out,
    input wire logic drivers_en_out,
    input wire logic run_out,
    input wire logic auto_start_out,
    input wire logic [2:0] seq_phase_out,
    input wire logic commutate_out,
    input wire logic ilim_half_out,
    input wire logic [15:0] ctrl_word_out,
    input wire logic [15:0] status_word_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // strobe high in a cycle that can launch a load through the synchroniser
    sequence s_recent_strobe;
        $past(strobe_in, 2) || $past(strobe_in, 3) || $past(strobe_in, 4);
    endsequence
    sequence s_dis_held;
        port_dis_in [*4];
    endsequence
    sequence s_reset_held;
        ctrl_word_out[7] [*3];
    endsequence

    a_latch_on_strobe: assert property ($changed(ctrl_word_out) |->
        s_recent_strobe) else $error("control word moved without strobe");
    a_lock_win_map: assert property (lock_win_cyc_out ==
        (16'h0640 << ctrl_word_out[3:2])) else $error("lock window wrong");
    a_wrap_bits_echo: assert property (status_word_out[1:0] ==
        ctrl_word_out[1:0]) else $error("status wrap bits wrong");
    a_drive_gate_off: assert property (ctrl_word_out[5] |->
        !drivers_en_out) else $error("drivers on while disabled");
    a_run_and_gate: assert property (!ctrl_word_out[6] |->
        !run_out) else $error("run without run bit");
    a_fdbk_int_sel: assert property (!ctrl_word_out[0] |->
        speed_fdbk_out == int_fdbk_in) else $error("feedback source wrong");
    a_auto_ilim_echo: assert property (auto_start_out ==
        ctrl_word_out[8] && ilim_half_out == ctrl_word_out[15])
        else $error("start mode or limit gain wrong");
    a_seq_hold_reset: assert property (s_reset_held |->
        seq_phase_out == 3'h0) else $error("sequencer not held at phase 1");
    a_oe_float_dis: assert property (s_dis_held |->
        !dio_oe_out) else $error("data driven while port disabled");
    a_comm_one_pulse: assert property (commutate_out |=>
        !commutate_out) else $error("commutation pulse too long");
    a_fref_gate_off: assert property (ctrl_word_out[1] |->
        !fref_pd_out) else $error("reference passed while blocked");
    a_resync_follow: assert property (resync_rst_out ==
        ctrl_word_out[5]) else $error("resync reset wrong");
    a_comm_on_fall: assert property (commutate_out ==
        $fell(status_word_out[3]))
        else $error("commutation not at delay fall");
endmodule : spcsr_props

bind spcsr_regs spcsr_props u_spcsr_props (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .strobe_in(strobe_in),
    .port_dis_in(port_dis_in), .int_fdbk_in(int_fdbk_in),
    .dio_oe_out(dio_oe_out), .speed_fdbk_out(speed_fdbk_out),
    .fref_pd_out(fref_pd_out), .resync_rst_out(resync_rst_out),
    .lock_win_cyc_out(lock_win_cyc_out), .drivers_en_out(drivers_en_out),
    .run_out(run_out), .auto_start_out(auto_start_out),
    .seq_phase_out(seq_phase_out), .commutate_out(commutate_out),
    .ilim_half_out(ilim_half_out), .ctrl_word_out(ctrl_word_out),
    .status_word_out(status_word_out));

// ---- testbench/spcsr_host.sv ----
// behavioural host driving the five-wire serial port
`timescale 1ns/10ps
module spcsr_host (
    input wire logic clk_sys_in,
    input wire logic dev_dat_in,
    input wire logic dev_oe_in,
    output logic port_clk_out,
    output logic strobe_out,
    output logic rw_out,
    output logic dis_out,
    output logic line_out,
    output logic [15:0] rd_word_out,
    output logic rd_done_out
);
    logic my_oe = 1'b0;
    logic my_dat = 1'b0;
    logic last = 1'b0;

    // undriven line toggles each cycle so no stale bit can pass
    always_comb line_out = dev_oe_in ? dev_dat_in : (my_oe ? my_dat : ~last);
    always @(posedge clk_sys_in) last <= line_out;

    // port idles disabled at start and after reads, clock still between frames
    initial begin
        port_clk_out = 1'b0;
        strobe_out = 1'b0;
        rw_out = 1'b0;
        dis_out = 1'b1;
        rd_word_out = 16'h0000;
        rd_done_out = 1'b0;
    end

    task automatic wait_sys(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : wait_sys

    // 16 bits, bit 0 first, sampled on falls, then the strobe latches
    task automatic write_word(input logic [15:0] w);
        wait_sys(1);
        rw_out = 1'b0;
        dis_out = 1'b0;
        wait_sys(4);
        my_oe = 1'b1;
        for (int i = 0; i < 16; i++) begin
            #31.25 my_dat = w[i];
            #31.25 port_clk_out = 1'b1;
            #62.5 port_clk_out = 1'b0;
        end
        #31.25 my_oe = 1'b0;
        wait_sys(4);
        strobe_out = 1'b1;
        wait_sys(4);
        strobe_out = 1'b0;
        wait_sys(4);
    endtask : write_word

    // strobe snapshots status, then bits come out on falls
    task automatic read_word();
        logic [15:0] r;
        wait_sys(1);
        rw_out = 1'b1;
        dis_out = 1'b0;
        wait_sys(4);
        strobe_out = 1'b1;
        wait_sys(4);
        strobe_out = 1'b0;
        wait_sys(4);
        for (int i = 0; i < 16; i++) begin
            r[i] = line_out;
            if (i < 15) begin
                #62.5 port_clk_out = 1'b1;
                #62.5 port_clk_out = 1'b0;
                #31.25;
            end
        end
        rd_word_out = r;
        rd_done_out = 1'b1;
        wait_sys(1);
        rd_done_out = 1'b0;
        dis_out = 1'b1;
        wait_sys(6);
    endtask : read_word
endmodule : spcsr_host

// ---- testbench/spcsr_regs_tb.sv ----
// self-checking bench for the spindle control/status register block
`timescale 1ns/10ps
module spcsr_regs_tb;
    logic clk_sys_in;
    logic rst_in;
    logic port_clk, strobe, rw, dis, dio_in, dio_out, dio_oe;
    logic run_pin, out_en, zero_cross, ext_fb, int_fb, fref, ref_60hz;
    logic [15:0] ctrl_word, status_word, rd_word, cur, w;
    logic rd_done;
    logic brake;
    logic [2:0] seq_phase;
    logic [15:0] exp_ctrl[$];
    logic [15:0] exp_rd[$];
    int errors, cmp_count;

    spcsr_regs #(.CYC_PER_MS(2), .BRAKE_DLY_CYC(20)) u_spcsr_regs (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .port_clk_in(port_clk),
        .strobe_in(strobe), .rw_in(rw), .port_dis_in(dis), .dio_in(dio_in),
        .dio_out(dio_out), .dio_oe_out(dio_oe), .run_pin_in(run_pin),
        .out_en_pin_in(out_en), .zero_cross_in(zero_cross),
        .ext_fdbk_in(ext_fb), .int_fdbk_in(int_fb), .fref_in(fref),
        .ref_60hz_in(ref_60hz), .speed_fdbk_out(), .fref_pd_out(),
        .lock_win_cyc_out(), .drivers_en_out(), .resync_rst_out(),
        .run_out(), .brake_out(brake), .auto_start_out(),
        .seq_phase_out(seq_phase),
        .commutate_out(), .ilim_half_out(), .ctrl_word_out(ctrl_word),
        .status_word_out(status_word));

    spcsr_host u_spcsr_host (
        .clk_sys_in(clk_sys_in), .dev_dat_in(dio_out), .dev_oe_in(dio_oe),
        .port_clk_out(port_clk), .strobe_out(strobe), .rw_out(rw),
        .dis_out(dis), .line_out(dio_in), .rd_word_out(rd_word),
        .rd_done_out(rd_done));

    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // pin levels wander so the gating paths see both values
    always @(negedge clk_sys_in) begin
        {ext_fb, int_fb, fref, out_en, ref_60hz} <= 5'($urandom);
    end

    task automatic check_word(input string what, input logic [15:0] exp,
                              input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // an unexpected change compares against the unchanged value and fails
    always @(ctrl_word) begin
        if (!rst_in) begin
            if (exp_ctrl.size() == 0) begin
                check_word("ctrl_word", cur, ctrl_word);
            end else begin
                check_word("ctrl_word", exp_ctrl.pop_front(), ctrl_word);
            end
        end
    end
    always @(posedge rd_done) begin
        check_word("status_word", exp_rd.pop_front(), rd_word);
    end

    // equal words give no output change, so only real changes are noted
    task automatic do_write(input logic [15:0] v);
        if (v !== cur) exp_ctrl.push_back(v);
        cur = v;
        u_spcsr_host.write_word(v);
    endtask : do_write
    task automatic do_read(input logic [15:0] e);
        exp_rd.push_back(e);
        u_spcsr_host.read_word();
    endtask : do_read

    initial begin
        void'($urandom(32'hE84C));
        errors = 0;
        cmp_count = 0;
        rst_in = 1'b1;
        run_pin = 1'b1;
        zero_cross = 1'b0;
        cur = 16'h756C;
        repeat (4) @(negedge clk_sys_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        check_word("ctrl_reset", 16'h756C, ctrl_word);
        check_word("status_reset", 16'h0014, status_word);
        do_read(16'h0014);
        // random words, drivers kept off so status stays idle
        for (int n = 0; n < 12; n++) begin
            w = 16'($urandom);
            w[5] = 1'b1;
            w[4] = 1'b0;
            do_write(w);
            do_read({11'h000, 2'b10, !w[9], w[1:0]});
        end
        // run rises with drivers on: alignment, then spin up
        do_write(16'h01A0);
        do_write(16'h1540);
        do_read(16'h0004);
        repeat (3000) @(negedge clk_sys_in);
        do_read(16'h0014);
        // crossings 240 cycles apart; the first delay is zero, the second is cut by the next
        for (int n = 0; n < 4; n++) begin
            zero_cross = 1'b1;
            repeat (120) @(negedge clk_sys_in);
            zero_cross = 1'b0;
            repeat (120) @(negedge clk_sys_in);
        end
        // status taken a few cycles after the fifth crossing
        zero_cross = 1'b1;
        do_read(16'h0018);
        zero_cross = 1'b0;
        check_word("seq_phase", 16'h0004, {13'h0000, seq_phase});
        // run pin drops: brake after the delay, sequencer held
        run_pin = 1'b0;
        repeat (40) @(negedge clk_sys_in);
        check_word("brake", 16'h0001, {15'h0000, brake});
        check_word("seq_hold", 16'h0000, {13'h0000, seq_phase});
        check_word("ctrl_final", cur, ctrl_word);
        check_word("ctrl_left", 16'h0000, 16'(exp_ctrl.size()));
        give_verdict();
    end

    // hang guard well past the expected run length
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        errors++;
        give_verdict();
    end
endmodule : spcsr_regs_tb
